/* File: logic/pin_edge.sv */
module pin_edge (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic pin,
    output logic      rise,
    output logic      fall
);
    logic prev_q;

    // Pin is already synchronous, one stage of history suffices
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= pin;
        end
    end

    assign rise = pin && !prev_q;
    assign fall = !pin && prev_q;
endmodule : pin_edge

/* File: logic/ten_bit_timer_control.sv */
// How it works
// - Pause bit freezes the counter; clearing it resumes from the held value
// - Clock select picks sys/4, sys, high/16, high/64, low, external edges
// - Reserved clock code gives no counting ticks at all
// - On bit rising clears counter; falling stops it and holds value
// - In compare mode, on bit rising restores the initial pin level
// - Period code compares counter bits 9..7; zero means 1024 clocks
// - Clear-source low clears on period match, or overflow when code zero
// - Clear-source high clears the counter on compare-A match
// - Clear-source bit is ignored in PWM, single pulse and capture modes
// - Mode field: compare, capture, PWM or single pulse, timer/counter
// - Compare mode: A match leaves, lowers, raises or toggles the pin
// - PWM mode: forced inactive, forced active, waveform or single pulse
// - Capture mode: rising, falling, both edges, or capture off
// - A match asking for the level already present changes nothing
// - Invert bit inverts the pin, except in timer/counter and capture modes
// - Swap bit exchanges period and duty roles of the two compares
// - Timer/counter mode leaves the pin undriven, function ignored
// - Both control registers reset to zero
// - Counter and compare-A are 10 bits, compare-A matches all of them
// - Matches set A and period flags, a capture sets A in capture mode; no period flag with clear-source high in compare and timer/counter modes
module ten_bit_timer_control
    import tmr_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [REG_W-1:0]  wdata,
    input  wire logic              wr_stb,
    input  wire logic              rd_stb,
    output logic      [REG_W-1:0]  rdata_q,
    input  wire logic              high_clk_tick,
    input  wire logic              low_clk_tick,
    input  wire logic              external_count_clock_pin,
    input  wire logic              timer_pin_a_in,
    output logic                   timer_pin_a_out_q,
    output logic                   timer_pin_a_oe_q,
    input  wire logic              timer_pin_b_in,
    output logic                   timer_pin_b_out_q,
    output logic                   timer_pin_b_oe_q,
    output logic                   compare_a_flag_q,
    output logic                   period_match_flag_q
);
    logic [REG_W-1:0] ctrl0_q;
    logic [REG_W-1:0] ctrl1_q;
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] compare_a_value_q;
    logic             level_q;
    logic             pulse_q;

    logic sys4_tick, hi16_tick, hi64_tick;
    logic ext_rise, ext_fall;
    logic cap_a_rise, cap_a_fall, cap_b_rise, cap_b_fall;

    clk_sel_e         count_clock_select;
    mode_e            mode_select;
    logic [1:0]       pin_function_select;
    logic [RP_W-1:0]  period_compare_value;
    logic             count_pause, timer_on, pin_initial_level, pin_invert;
    logic             period_duty_swap, clear_source_select;

    assign count_pause          = ctrl0_q[C0_PAUSE];
    assign count_clock_select   = clk_sel_e'(ctrl0_q[C0_CK_HI:C0_CK_LO]);
    assign timer_on             = ctrl0_q[C0_ON];
    assign period_compare_value = ctrl0_q[C0_RP_HI:0];
    assign mode_select          = mode_e'(ctrl1_q[C1_MD_HI:C1_MD_LO]);
    assign pin_function_select  = ctrl1_q[C1_FN_HI:C1_FN_LO];
    assign pin_initial_level    = ctrl1_q[C1_INIT];
    assign pin_invert           = ctrl1_q[C1_INV];
    assign period_duty_swap     = ctrl1_q[C1_SWAP];
    assign clear_source_select  = ctrl1_q[C1_CLR];

    tick_divider #(.DIV(SYS_DIV)) u_div_sys (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .tick_in  (1'b1),
        .tick_out (sys4_tick)
    );

    tick_divider #(.DIV(HIGH_DIV1)) u_div_hi16 (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .tick_in  (high_clk_tick),
        .tick_out (hi16_tick)
    );

    tick_divider #(.DIV(HIGH_DIV2)) u_div_hi64 (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .tick_in  (high_clk_tick),
        .tick_out (hi64_tick)
    );

    pin_edge u_ext_edge (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pin      (external_count_clock_pin),
        .rise     (ext_rise),
        .fall     (ext_fall)
    );

    pin_edge u_cap_a_edge (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pin      (timer_pin_a_in),
        .rise     (cap_a_rise),
        .fall     (cap_a_fall)
    );

    pin_edge u_cap_b_edge (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pin      (timer_pin_b_in),
        .rise     (cap_b_rise),
        .fall     (cap_b_fall)
    );

    logic src_tick;
    always_comb begin
        case (count_clock_select)
            CK_SYS4:  src_tick = sys4_tick;
            CK_SYS:   src_tick = 1'b1;
            CK_HI16:  src_tick = hi16_tick;
            CK_HI64:  src_tick = hi64_tick;
            CK_LOW:   src_tick = low_clk_tick;
            CK_EXT_R: src_tick = ext_rise;
            CK_EXT_F: src_tick = ext_fall;
            default:  src_tick = 1'b0;
        endcase
    end

    logic wr_ctrl0, wr_ctrl1, on_rise, count_en;
    assign wr_ctrl0 = wr_stb && (addr == ADDR_CTRL0);
    assign wr_ctrl1 = wr_stb && (addr == ADDR_CTRL1);
    assign on_rise  = wr_ctrl0 && wdata[C0_ON] && !timer_on;
    assign count_en = src_tick && timer_on && !count_pause;

    logic [CNT_W-1:0] count_next;
    logic             p_match, a_match, p_clear, cmp_like;
    assign count_next = CNT_W'(count_q + 1'b1);
    // Code zero wraps to 0 with bits 6..0 clear, so overflow is the match
    assign p_match = count_en
        && (count_next[CNT_W-1:STEP_BITS] == period_compare_value)
        && (count_next[STEP_BITS-1:0] == '0);
    assign a_match  = count_en && (count_next == compare_a_value_q);
    assign cmp_like = (mode_select == MODE_CMP)
                   || (mode_select == MODE_TMR);

    always_comb begin
        case (mode_select)
            MODE_PWM: p_clear = period_duty_swap ? a_match : p_match;
            MODE_CAP: p_clear = p_match;
            default:  p_clear = clear_source_select ? a_match
                                                    : p_match;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            count_q <= CNT_RST;
        end else if (on_rise) begin
            count_q <= CNT_RST;
        end else if (count_en) begin
            count_q <= p_clear ? CNT_RST : count_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl0_q <= CTRL0_RST;
            ctrl1_q <= CTRL1_RST;
        end else begin
            if (wr_ctrl0) ctrl0_q <= wdata;
            if (wr_ctrl1) ctrl1_q <= wdata;
        end
    end

    logic capture;
    always_comb begin
        case (pin_function_select)
            FN_RISE: capture = cap_a_rise || cap_b_rise;
            FN_FALL: capture = cap_a_fall || cap_b_fall;
            FN_BOTH: capture = cap_a_rise || cap_a_fall
                            || cap_b_rise || cap_b_fall;
            default: capture = 1'b0;
        endcase
        capture = capture && timer_on && (mode_select == MODE_CAP);
    end

    // Capture overrides a software write in the same cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            compare_a_value_q <= CNT_RST;
        end else if (capture) begin
            compare_a_value_q <= count_q;
        end else if (wr_stb && addr == ADDR_CMPA_LO) begin
            compare_a_value_q[REG_W-1:0] <= wdata;
        end else if (wr_stb && addr == ADDR_CMPA_HI) begin
            compare_a_value_q[CNT_W-1:REG_W] <= wdata[CNT_W-REG_W-1:0];
        end
    end

    logic clr_flags;
    logic set_a, set_p;
    assign clr_flags = wr_stb && (addr == ADDR_FLAGS);
    assign set_a = (mode_select == MODE_CAP) ? capture : a_match;
    assign set_p = p_match && !(cmp_like && clear_source_select);

    // Hardware set wins over a write-one clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            compare_a_flag_q    <= 1'b0;
            period_match_flag_q <= 1'b0;
        end else begin
            compare_a_flag_q <= set_a
                || (compare_a_flag_q && !(clr_flags && wdata[FLAG_A]));
            period_match_flag_q <= set_p
                || (period_match_flag_q && !(clr_flags && wdata[FLAG_P]));
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            level_q <= 1'b0;
        end else if (on_rise) begin
            level_q <= ctrl1_q[C1_INIT];
        end else if (a_match && mode_select == MODE_CMP) begin
            case (pin_function_select)
                FN_LOW:    level_q <= 1'b0;
                FN_HIGH:   level_q <= 1'b1;
                FN_TOGGLE: level_q <= !level_q;
                default:   level_q <= level_q;
            endcase
        end
    end

    // Single pulse opens at switch-on and closes at the duty match
    logic duty_match;
    assign duty_match = period_duty_swap ? p_match : a_match;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pulse_q <= 1'b0;
        end else if (on_rise) begin
            pulse_q <= 1'b1;
        end else if (duty_match || !timer_on) begin
            pulse_q <= 1'b0;
        end
    end

    logic [CNT_W:0] duty_len;
    logic           wave_act, pin_level, pin_drive;
    always_comb begin
        if (period_duty_swap) begin
            duty_len = {1'b0, period_compare_value, 7'h00};
            if (period_compare_value == '0) duty_len = 11'h400;
        end else begin
            duty_len = {1'b0, compare_a_value_q};
        end
        wave_act = timer_on && ({1'b0, count_q} < duty_len);
        case (pin_function_select)
            FN_ACT:   pin_level = pin_initial_level;
            FN_WAVE:  pin_level = wave_act ? pin_initial_level
                                           : !pin_initial_level;
            FN_PULSE: pin_level = pulse_q ? pin_initial_level
                                          : !pin_initial_level;
            default:  pin_level = !pin_initial_level;
        endcase
        if (mode_select == MODE_CMP) pin_level = level_q;
        pin_drive = (mode_select == MODE_CMP)
                 || (mode_select == MODE_PWM);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            timer_pin_a_out_q <= 1'b0;
            timer_pin_b_out_q <= 1'b0;
            timer_pin_a_oe_q  <= 1'b0;
            timer_pin_b_oe_q  <= 1'b0;
        end else begin
            timer_pin_a_out_q <= pin_drive && (pin_level ^ pin_invert);
            timer_pin_b_out_q <= pin_drive && (pin_level ^ pin_invert);
            timer_pin_a_oe_q  <= pin_drive;
            timer_pin_b_oe_q  <= pin_drive;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else if (rd_stb) begin
            case (addr)
                ADDR_CTRL0:   rdata_q <= ctrl0_q;
                ADDR_CTRL1:   rdata_q <= ctrl1_q;
                ADDR_CNT_LO:  rdata_q <= count_q[REG_W-1:0];
                ADDR_CNT_HI:  rdata_q <= {6'h00, count_q[CNT_W-1:REG_W]};
                ADDR_CMPA_LO: rdata_q <= compare_a_value_q[REG_W-1:0];
                ADDR_CMPA_HI: rdata_q <= {6'h00,
                                          compare_a_value_q[CNT_W-1:REG_W]};
                ADDR_FLAGS:   rdata_q <= {6'h00, period_match_flag_q,
                                          compare_a_flag_q};
                default:      rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence on_rise_cmp_s;
        on_rise && mode_select == MODE_CMP && !wr_ctrl1
            && compare_a_value_q > 10'h002;
    endsequence

    pause_hold_a: assert property (
        count_pause && !on_rise |=> count_q == $past(count_q))
        else $error("counter moved while paused");

    reserved_clk_a: assert property (
        count_clock_select == CK_RSVD && !on_rise
            |=> count_q == $past(count_q))
        else $error("counter moved on reserved clock");

    on_clear_a: assert property (
        on_rise |=> count_q == CNT_RST)
        else $error("switch-on did not clear counter");

    off_hold_a: assert property (
        (!timer_on && !on_rise) [*2] |=> $stable(count_q))
        else $error("counter moved while off");

    init_level_a: assert property (
        on_rise_cmp_s ##1 !wr_ctrl1 |=> timer_pin_a_out_q
            == (ctrl1_q[C1_INIT] ^ ctrl1_q[C1_INV]))
        else $error("pin not at initial level after switch-on");

    step_one_a: assert property (
        count_en && !p_clear && !on_rise
            |=> count_q == CNT_W'($past(count_q) + 1'b1))
        else $error("counter did not step by one");

    period_clear_a: assert property (
        p_match && cmp_like && !clear_source_select && !on_rise
            |=> count_q == CNT_RST)
        else $error("period match did not clear counter");

    no_pflag_a: assert property (
        $rose(period_match_flag_q)
            |-> !($past(cmp_like) && $past(clear_source_select)))
        else $error("period flag set with clear-source high");

    toggle_pin_a: assert property (
        a_match && mode_select == MODE_CMP && !on_rise
            && pin_function_select == FN_TOGGLE |=> level_q != $past(level_q))
        else $error("compare match did not toggle");

    tmr_undriven_a: assert property (
        mode_select == MODE_TMR |=> !timer_pin_a_oe_q && !timer_pin_b_oe_q)
        else $error("pin driven in timer/counter mode");
endmodule : ten_bit_timer_control

/* File: logic/tick_divider.sv */
module tick_divider #(
    parameter int DIV = 4
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic tick_in,
    output logic      tick_out
);
    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_q;

    if (DIV < 2) begin : g_div_check
        $error("tick_divider: DIV below 2");
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (tick_in) begin
            cnt_q <= (cnt_q == LAST) ? '0 : CW'(cnt_q + 1'b1);
        end
    end

    assign tick_out = tick_in && (cnt_q == LAST);
endmodule : tick_divider

/* File: logic/tmr_pkg.sv */
package tmr_pkg;
    localparam int CNT_W      = 10;
    localparam int REG_W      = 8;
    localparam int ADDR_W     = 3;
    localparam int RP_W       = 3;
    localparam int STEP_BITS  = 7;

    localparam logic [ADDR_W-1:0] ADDR_CTRL0   = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_CTRL1   = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_CNT_LO  = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_CNT_HI  = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_CMPA_LO = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_CMPA_HI = 3'h5;
    localparam logic [ADDR_W-1:0] ADDR_FLAGS   = 3'h6;

    localparam logic [REG_W-1:0] CTRL0_RST = 8'h00;
    localparam logic [REG_W-1:0] CTRL1_RST = 8'h00;
    localparam logic [CNT_W-1:0] CNT_RST   = 10'h000;

    localparam int C0_PAUSE  = 7;
    localparam int C0_CK_HI  = 6;
    localparam int C0_CK_LO  = 4;
    localparam int C0_ON     = 3;
    localparam int C0_RP_HI  = 2;
    localparam int C1_MD_HI  = 7;
    localparam int C1_MD_LO  = 6;
    localparam int C1_FN_HI  = 5;
    localparam int C1_FN_LO  = 4;
    localparam int C1_INIT   = 3;
    localparam int C1_INV    = 2;
    localparam int C1_SWAP   = 1;
    localparam int C1_CLR    = 0;
    localparam int FLAG_A    = 0;
    localparam int FLAG_P    = 1;

    localparam int SYS_DIV   = 4;
    localparam int HIGH_DIV1 = 16;
    localparam int HIGH_DIV2 = 64;

    typedef enum logic [2:0] {
        CK_SYS4 = 3'h0, CK_SYS = 3'h1, CK_HI16 = 3'h2, CK_HI64 = 3'h3,
        CK_LOW  = 3'h4, CK_RSVD = 3'h5, CK_EXT_R = 3'h6, CK_EXT_F = 3'h7
    } clk_sel_e;

    typedef enum logic [1:0] {
        MODE_CMP = 2'h0, MODE_CAP = 2'h1, MODE_PWM = 2'h2, MODE_TMR = 2'h3
    } mode_e;

    localparam logic [1:0] FN_LOW    = 2'h1;
    localparam logic [1:0] FN_HIGH   = 2'h2;
    localparam logic [1:0] FN_TOGGLE = 2'h3;
    localparam logic [1:0] FN_ACT    = 2'h1;
    localparam logic [1:0] FN_WAVE   = 2'h2;
    localparam logic [1:0] FN_PULSE  = 2'h3;
    localparam logic [1:0] FN_RISE   = 2'h0;
    localparam logic [1:0] FN_FALL   = 2'h1;
    localparam logic [1:0] FN_BOTH   = 2'h2;
endpackage : tmr_pkg

/* File: verification/pin_far_side.sv */
module pin_far_side (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic ext_run,
    output logic      high_clk_tick,
    output logic      low_clk_tick,
    output logic      ext_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] ph_q;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ph_q <= 3'h0;
        end else begin
            ph_q <= ph_q + 3'h1;
        end
    end

    assign high_clk_tick = ph_q[0];
    assign low_clk_tick  = (ph_q == 3'h7);

    // Stands still unless a run is ordered, like a real gated source
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ext_pin <= 1'b0;
        end else if (ext_run && ph_q[0]) begin
            ext_pin <= ~ext_pin;
        end
    end
endmodule : pin_far_side

/* File: verification/ten_bit_timer_control_tb.sv */
module ten_bit_timer_control_tb
    import tmr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              core_clk = 1'b0;
    logic              rst_n    = 1'b0;
    logic [ADDR_W-1:0] addr     = '0;
    logic [REG_W-1:0]  wdata    = '0;
    logic              wr_stb   = 1'b0;
    logic              rd_stb   = 1'b0;
    logic              ext_run  = 1'b0;
    logic              far_a    = 1'b0;
    logic [REG_W-1:0]  rdata_q;
    logic              hi_tick, lo_tick, ext_pin;
    logic              out_a, oe_a, out_b, oe_b, flag_a, flag_p;
    logic              pin_a_w, pin_b_w;
    int                mismatches = 0;
    int                compares   = 0;

    always #5 core_clk = ~core_clk;

    // Wire level: whoever enables wins, released pin b pulled low
    assign pin_a_w = oe_a ? out_a : far_a;
    assign pin_b_w = oe_b ? out_b : 1'b0;

    pin_far_side i_far (.core_clk(core_clk), .rst_n(rst_n),
        .ext_run(ext_run), .high_clk_tick(hi_tick),
        .low_clk_tick(lo_tick), .ext_pin(ext_pin));

    ten_bit_timer_control i_dut (.core_clk(core_clk), .rst_n(rst_n),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata_q(rdata_q), .high_clk_tick(hi_tick),
        .low_clk_tick(lo_tick), .external_count_clock_pin(ext_pin),
        .timer_pin_a_in(pin_a_w), .timer_pin_a_out_q(out_a),
        .timer_pin_a_oe_q(oe_a), .timer_pin_b_in(pin_b_w),
        .timer_pin_b_out_q(out_b), .timer_pin_b_oe_q(oe_b),
        .compare_a_flag_q(flag_a), .period_match_flag_q(flag_p));

    task automatic final_report();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge core_clk);
        wr_stb <= 1'b0;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
        @(posedge core_clk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge core_clk);
        rd_stb <= 1'b0;
        #1;
        d = rdata_q;
    endtask : rd

    task automatic rdcnt(output logic [CNT_W-1:0] v);
        logic [7:0] lo, hi;
        rd(ADDR_CNT_LO, lo);
        rd(ADDR_CNT_HI, hi);
        v = {hi[1:0], lo};
    endtask : rdcnt

    task automatic start(input logic [7:0] c1, input logic [7:0] c0);
        wr(ADDR_CTRL0, 8'h00);
        wr(ADDR_CTRL1, c1);
        wr(ADDR_FLAGS, 8'h03);
        wr(ADDR_CTRL0, c0);
    endtask : start

    // Bounded so a dead flag cannot hang the run
    task automatic wait_flag(input bit per, output int n);
        n = 0;
        while (((per ? flag_p : flag_a) !== 1'b1) && n < 2000) begin
            @(posedge core_clk);
            #1;
            n++;
        end
    endtask : wait_flag

    // Ticks expected in about 256 system cycles per clock code
    function automatic int clk_ticks(input int ck);
        case (ck)
            0: return 64;
            1: return 256;
            2: return 8;
            3: return 2;
            4: return 32;
            5: return 0;
            default: return 64;
        endcase
    endfunction : clk_ticks

    initial begin
        repeat (40000) @(posedge core_clk);
        mismatches++;
        final_report();
    end

    initial begin
        logic [7:0]       b;
        logic [CNT_W-1:0] v, v2;
        logic [31:0]      r;
        logic             lvl;
        int               n, e, t, act;
        static int pc[3] = '{1, 3, 0};
        static int pf[5] = '{0, 1, 2, 2, 3};
        static int sw[5] = '{0, 0, 0, 1, 0};
        static int pa[5] = '{64, 64, 64, 192, 30};
        static int pw[5] = '{128, 128, 256, 384, 256};
        static int pe[5] = '{0, 128, 128, 256, 30};
        r = $urandom(32'hed5a333c);
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(ADDR_CTRL0, b);
        chk(b, 8'h00);
        rd(ADDR_CTRL1, b);
        chk(b, 8'h00);
        rd(3'h7, b);
        chk(b, 8'h00);
        r = $urandom;
        wr(ADDR_CTRL1, r[7:0]);
        rd(ADDR_CTRL1, b);
        chk(b, r[7:0]);
        wr(ADDR_CTRL0, r[15:8] & 8'hf7);
        rd(ADDR_CTRL0, b);
        chk(b, r[15:8] & 8'hf7);
        ext_run <= 1'b1;
        for (int ck = 0; ck < 8; ck++) begin
            start(8'hc0, {1'b0, ck[2:0], 4'h8});
            cyc(256);
            wr(ADDR_CTRL0, {1'b1, ck[2:0], 4'h8});
            rdcnt(v);
            e = clk_ticks(ck);
            t = (e == 0) ? 0 : 2 + e / 32;
            chk(v + t >= e && v <= e + t, 1'b1);
            chk(oe_a, 1'b0);
            chk(oe_b, 1'b0);
            cyc(20);
            rdcnt(v2);
            chk(v2, v);
            wr(ADDR_CTRL0, {1'b0, ck[2:0], 4'h8});
            cyc(140);
            rdcnt(v2);
            chk(v2 > v || e == 0, 1'b1);
            wr(ADDR_CTRL0, {1'b0, ck[2:0], 4'h0});
            rdcnt(v);
            cyc(20);
            rdcnt(v2);
            chk(v2, v);
        end
        ext_run <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            start(8'hc0, {4'h1, 1'b1, pc[i][2:0]});
            wait_flag(1'b1, n);
            e = (pc[i] == 0) ? 1024 : pc[i] * 128;
            chk(n + 4 >= e && n <= e + 4, 1'b1);
            rdcnt(v);
            chk(v < 16, 1'b1);
        end
        wr(ADDR_CMPA_LO, 8'hc8);
        wr(ADDR_CMPA_HI, 8'h00);
        for (int fn = 0; fn < 4; fn++) begin
            r = $urandom;
            start({2'b00, fn[1:0], r[1:0], 2'b01}, 8'h19);
            cyc(2);
            chk(out_a, r[1] ^ r[0]);
            chk(oe_a, 1'b1);
            chk(oe_b, 1'b1);
            wait_flag(1'b0, n);
            chk(n + 4 >= 200 && n <= 204, 1'b1);
            cyc(2);
            lvl = (fn == 1) ? 1'b0 : (fn == 2) ? 1'b1
                : (fn == 3) ? ~r[1] : r[1];
            chk(out_a, lvl ^ r[0]);
            chk(out_b, lvl ^ r[0]);
            chk(flag_p, 1'b0);
            rdcnt(v);
            chk(v < 16, 1'b1);
        end
        for (int i = 0; i < 5; i++) begin
            r = $urandom;
            wr(ADDR_CMPA_LO, pa[i][7:0]);
            wr(ADDR_CMPA_HI, {6'h00, pa[i][9:8]});
            start({2'b10, pf[i][1:0], r[1:0], sw[i][0], 1'b1}, 8'h19);
            act = 0;
            repeat (pw[i]) begin
                @(posedge core_clk);
                #1;
                act += (out_a === (r[1] ^ r[0]));
            end
            chk(act + 4 >= pe[i] && act <= pe[i] + 4, 1'b1);
        end
        for (int fn = 0; fn < 4; fn++) begin
            start({2'b01, fn[1:0], 4'h0}, 8'h18);
            cyc(4);
            chk(oe_a, 1'b0);
            chk(oe_b, 1'b0);
            @(posedge core_clk);
            far_a <= 1'b1;
            cyc(6);
            chk(flag_a, fn == 0 || fn == 2);
            wr(ADDR_FLAGS, 8'h01);
            far_a <= 1'b0;
            cyc(6);
            chk(flag_a, fn == 1 || fn == 2);
        end
        final_report();
    end
endmodule : ten_bit_timer_control_tb
